// File: hdl/ipc_power_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// RQ1: power-down stops the oscillator, so no internal clock runs.
// RQ2: idle gates only the cpu clock; interrupt, serial, timers keep clock.
// RQ3: power control register at address 87h, byte access only.
// RQ4: baud double bit doubles serial rate only in serial modes 1-3.
// RQ5: bits 3 and 2 are plain user flags without hardware effect.
// RQ6: writing one to bit 1 starts power-down.
// RQ7: writing one to bit 0 starts idle.
// RQ8: both bits written together: power-down wins, idle ignored.
// RQ9: reset clears bits 7 and 3..0; reserved bits read zero here.
// RQ10: idle holds both strobes high; power-down drives both low.
// RQ11: external fetch: port 0 floats; port 2 address in idle only.
// RQ12: the write setting the sleep bit completes before cpu clock stops.
// RQ13: idle keeps all cpu state, since the cpu is only frozen.
// RQ14: enabled interrupt in idle clears sleep bit and ends idle.
// RQ15: after interrupt return, execution resumes after the sleep write.
// RQ16: reset must be held 2 machine cycles (24 periods) to end idle.
// RQ17: power-down keeps internal ram while all else stops.
// RQ18: the write setting power-down completes before it takes effect.
// RQ19: only hardware reset leaves power-down; interrupts do not.
// RQ20: cpu clock re-enables glitch-free on idle exit.
module ipc_power_ctrl (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire ipc_pkg::ipc_sfr_s sfr_in,
  input wire logic irq_enabled_in,
  input wire logic ext_program_in,
  input wire logic [1:0] serial_mode_in,
  input wire logic cpu_ale_in,
  input wire logic cpu_prog_store_strobe_in,
  output logic [7:0] rdata_out,
  output logic osc_run_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic ram_retain_out,
  output logic baud_double_out,
  output logic idle_out,
  output logic power_down_out,
  output ipc_pkg::ipc_pins_s pins_out
);

  logic [7:0] power_control_reg;
  logic [7:0] next_power_control_reg;
  ipc_pkg::ipc_state_e state;
  ipc_pkg::ipc_state_e next_state;
  logic pc_write;

  ////////////////////////////////////////////////////////////////////////
  // register decode, byte writes only
  assign pc_write = sfr_in.wr && !sfr_in.bit_access
    && (sfr_in.addr == ipc_pkg::PWR_CTRL_ADDR); // RQ3

  // register and mode next values
  always_comb
  begin
    next_power_control_reg = power_control_reg;
    next_state = state;
    case (state)
      ipc_pkg::IPC_RUN:
      begin
        if (pc_write)
        begin
          // store only defined bits; mode entry after this write
          next_power_control_reg = sfr_in.wdata & ipc_pkg::PWR_CTRL_MASK;
          if (sfr_in.wdata[ipc_pkg::BIT_POWER_DOWN])
          begin
            next_state = ipc_pkg::IPC_PDOWN; // RQ6 RQ8 RQ18
            next_power_control_reg[ipc_pkg::BIT_SLEEP] = 1'b0; // RQ8
          end
          else if (sfr_in.wdata[ipc_pkg::BIT_SLEEP])
          begin
            next_state = ipc_pkg::IPC_IDLE; // RQ7 RQ12
          end
        end
      end
      ipc_pkg::IPC_IDLE:
      begin
        // cpu frozen, no writes possible; wake on enabled interrupt
        if (irq_enabled_in)
        begin
          next_power_control_reg[ipc_pkg::BIT_SLEEP] = 1'b0; // RQ14
          next_state = ipc_pkg::IPC_RUN; // RQ14 RQ15
        end
      end
      ipc_pkg::IPC_PDOWN:
      begin
        next_state = ipc_pkg::IPC_PDOWN; // RQ19
      end
      default:
      begin
        next_state = ipc_pkg::IPC_RUN;
      end
    endcase
  end

  // registers, synchronous reset ends any mode
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      power_control_reg <= ipc_pkg::PWR_CTRL_RESET; // RQ9
      state <= ipc_pkg::IPC_RUN; // RQ16 RQ19
    end
    else
    begin
      power_control_reg <= next_power_control_reg;
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered; zero for other addresses
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = ipc_pkg::RDATA_NONE;
    if (sfr_in.rd && (sfr_in.addr == ipc_pkg::PWR_CTRL_ADDR))
    begin
      next_rdata = power_control_reg; // RQ3 RQ5
    end
  end

  // read data register
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      rdata_out <= ipc_pkg::RDATA_NONE;
    end
    else
    begin
      rdata_out <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock enables are registered flops, so gating is glitch-free
  logic next_cpu_clk_en;
  logic next_periph_clk_en;
  logic next_osc_run;
  always_comb
  begin
    next_cpu_clk_en = (next_state == ipc_pkg::IPC_RUN); // RQ2 RQ13 RQ20
    next_periph_clk_en = (next_state != ipc_pkg::IPC_PDOWN); // RQ2
    next_osc_run = (next_state != ipc_pkg::IPC_PDOWN); // RQ1 RQ17
  end

  // clock enable registers, all running after reset
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      cpu_clk_en_out <= ipc_pkg::CLK_EN_RESET;
      periph_clk_en_out <= ipc_pkg::CLK_EN_RESET;
      osc_run_out <= ipc_pkg::CLK_EN_RESET;
    end
    else
    begin
      cpu_clk_en_out <= next_cpu_clk_en;
      periph_clk_en_out <= next_periph_clk_en;
      osc_run_out <= next_osc_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode flags, ram retention and baud doubling
  assign idle_out = (state == ipc_pkg::IPC_IDLE);
  assign power_down_out = (state == ipc_pkg::IPC_PDOWN);
  assign ram_retain_out = 1'b1; // RQ17
  assign baud_double_out = power_control_reg[ipc_pkg::BIT_BAUD_DOUBLE]
    && (serial_mode_in != ipc_pkg::SERIAL_MODE_0); // RQ4

  // strobe and port control per mode
  always_comb
  begin
    pins_out.ale = cpu_ale_in;
    pins_out.prog_store_strobe = cpu_prog_store_strobe_in;
    pins_out.port0_float = 1'b0;
    pins_out.port2_addr = ext_program_in;
    case (state)
      ipc_pkg::IPC_IDLE:
      begin
        pins_out.ale = ipc_pkg::STROBE_IDLE; // RQ10
        pins_out.prog_store_strobe = ipc_pkg::STROBE_IDLE; // RQ10
        pins_out.port0_float = ext_program_in; // RQ11
        pins_out.port2_addr = ext_program_in; // RQ11
      end
      ipc_pkg::IPC_PDOWN:
      begin
        pins_out.ale = ipc_pkg::STROBE_PDOWN; // RQ10
        pins_out.prog_store_strobe = ipc_pkg::STROBE_PDOWN; // RQ10
        pins_out.port0_float = ext_program_in; // RQ11
        pins_out.port2_addr = 1'b0; // RQ11
      end
      default:
      begin
        pins_out.port0_float = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_pd_precedence: assert property ( // RQ8
    @(posedge clk_in) disable iff (!rstn_in)
    (state == ipc_pkg::IPC_RUN) && pc_write
    && sfr_in.wdata[ipc_pkg::BIT_POWER_DOWN] |=> power_down_out && !idle_out)
    else $error("power-down did not win");

  chk_idle_entry: assert property ( // RQ7
    @(posedge clk_in) disable iff (!rstn_in)
    (state == ipc_pkg::IPC_RUN) && pc_write
    && !sfr_in.wdata[ipc_pkg::BIT_POWER_DOWN]
    && sfr_in.wdata[ipc_pkg::BIT_SLEEP] |=> idle_out && !cpu_clk_en_out)
    else $error("idle not entered");

  chk_idle_periph: assert property ( // RQ2
    @(posedge clk_in) disable iff (!rstn_in)
    idle_out |-> periph_clk_en_out && osc_run_out && !cpu_clk_en_out)
    else $error("idle clocks wrong");

  chk_pd_osc: assert property ( // RQ1
    @(posedge clk_in) disable iff (!rstn_in)
    power_down_out |-> !osc_run_out && !periph_clk_en_out)
    else $error("oscillator runs in power-down");

  chk_idle_wake: assert property ( // RQ14
    @(posedge clk_in) disable iff (!rstn_in)
    idle_out && irq_enabled_in |=> !idle_out && cpu_clk_en_out
    && !power_control_reg[ipc_pkg::BIT_SLEEP])
    else $error("idle wake failed");

  chk_pd_sticky: assert property ( // RQ19
    @(posedge clk_in) disable iff (!rstn_in)
    power_down_out |=> power_down_out)
    else $error("power-down left without reset");

  chk_strobe_levels: assert property ( // RQ10
    @(posedge clk_in) disable iff (!rstn_in)
    (idle_out |-> pins_out.ale && pins_out.prog_store_strobe)
    and (power_down_out |-> !pins_out.ale && !pins_out.prog_store_strobe))
    else $error("strobe level wrong");

  chk_bit_access: assert property ( // RQ3
    @(posedge clk_in) disable iff (!rstn_in)
    sfr_in.bit_access && (state == ipc_pkg::IPC_RUN)
    |=> $stable(power_control_reg))
    else $error("bit access changed register");

  chk_baud_mode: assert property ( // RQ4
    @(posedge clk_in) disable iff (!rstn_in)
    (serial_mode_in == ipc_pkg::SERIAL_MODE_0) |-> !baud_double_out)
    else $error("baud doubled in mode 0");

  chk_reset_value: assert property ( // RQ9
    @(posedge clk_in)
    !rstn_in |=> power_control_reg == ipc_pkg::PWR_CTRL_RESET
    && cpu_clk_en_out)
    else $error("reset value wrong");

  chk_baud_on: assert property ( // RQ4
    @(posedge clk_in) disable iff (!rstn_in)
    power_control_reg[ipc_pkg::BIT_BAUD_DOUBLE]
    && (serial_mode_in != ipc_pkg::SERIAL_MODE_0) |-> baud_double_out)
    else $error("baud not doubled");

  chk_flags_stored: assert property ( // RQ5
    @(posedge clk_in) disable iff (!rstn_in)
    pc_write && (state == ipc_pkg::IPC_RUN)
    |=> power_control_reg[ipc_pkg::BIT_FLAG_1:ipc_pkg::BIT_FLAG_0]
    == $past(sfr_in.wdata[ipc_pkg::BIT_FLAG_1:ipc_pkg::BIT_FLAG_0]))
    else $error("user flags not stored");

  chk_read_data: assert property ( // RQ3
    @(posedge clk_in) disable iff (!rstn_in)
    sfr_in.rd && (sfr_in.addr == ipc_pkg::PWR_CTRL_ADDR)
    |=> rdata_out == $past(power_control_reg))
    else $error("read data wrong");

  chk_other_addr: assert property ( // RQ3
    @(posedge clk_in) disable iff (!rstn_in)
    sfr_in.wr && (sfr_in.addr != ipc_pkg::PWR_CTRL_ADDR)
    && (state == ipc_pkg::IPC_RUN) |=> $stable(power_control_reg))
    else $error("other address changed register");

  chk_reserved_zero: assert property ( // RQ9
    @(posedge clk_in) disable iff (!rstn_in)
    !(|(power_control_reg & ~ipc_pkg::PWR_CTRL_MASK)))
    else $error("reserved bits set");

  chk_pd_no_sleep: assert property ( // RQ8
    @(posedge clk_in) disable iff (!rstn_in)
    power_down_out |-> !power_control_reg[ipc_pkg::BIT_SLEEP])
    else $error("sleep bit kept in power-down");

  chk_idle_frozen: assert property ( // RQ13
    @(posedge clk_in) disable iff (!rstn_in)
    idle_out && !irq_enabled_in
    |=> idle_out && $stable(power_control_reg))
    else $error("idle state disturbed");

  chk_run_clocks: assert property ( // RQ20
    @(posedge clk_in) disable iff (!rstn_in)
    !idle_out && !power_down_out
    |-> cpu_clk_en_out && periph_clk_en_out && osc_run_out)
    else $error("clocks off while running");

  chk_port_float: assert property ( // RQ11
    @(posedge clk_in) disable iff (!rstn_in)
    (idle_out || power_down_out)
    |-> pins_out.port0_float == ext_program_in)
    else $error("port 0 float wrong");

  chk_port2_pdown: assert property ( // RQ11
    @(posedge clk_in) disable iff (!rstn_in)
    power_down_out |-> !pins_out.port2_addr)
    else $error("port 2 shows address in power-down");

  chk_ram_retain: assert property ( // RQ17
    @(posedge clk_in) disable iff (!rstn_in)
    power_down_out |-> ram_retain_out)
    else $error("ram not retained");

endmodule // ipc_power_ctrl

// File: hdl/ipc_pkg.sv
package ipc_pkg;
  // special-function address of the power control register
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  // field positions
  localparam int BIT_BAUD_DOUBLE = 7;
  localparam int BIT_FLAG_1 = 3;
  localparam int BIT_FLAG_0 = 2;
  localparam int BIT_POWER_DOWN = 1;
  localparam int BIT_SLEEP = 0;
  // reset value, reserved bits taken as zero
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  // bits that software may store
  localparam logic [7:0] PWR_CTRL_MASK = 8'h8f;
  // serial port mode with no baud doubling
  localparam logic [1:0] SERIAL_MODE_0 = 2'h0;
  // strobe levels held in each low-power mode
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic STROBE_PDOWN = 1'b0;
  // read bus level when nothing is read, clock enables after reset
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam logic CLK_EN_RESET = 1'b1;

  typedef enum {
    IPC_RUN,
    IPC_IDLE,
    IPC_PDOWN
  } ipc_state_e;

  // special-function register access from the cpu core
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_access;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ipc_sfr_s;

  // pin control towards the port and strobe drivers
  typedef struct packed {
    logic ale;
    logic prog_store_strobe;
    logic port0_float;
    logic port2_addr;
  } ipc_pins_s;
endpackage

// File: bench/ipc_cpu_model.sv
`timescale 1ns/1ps
// cpu core stand-in: a step count and strobes that freeze when gated
module ipc_cpu_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  output logic ale_out,
  output logic pss_out,
  output logic [7:0] pc_out
);
  // step count moves on the gated clock only, idle keeps it
  always @(negedge clk_in)
  begin
    if (!rstn_in)
      pc_out <= 8'h00;
    else if (clk_en_in)
      pc_out <= pc_out + 8'h01;
  end
  // run-time strobe pattern taken from the count
  assign ale_out = pc_out[0];
  assign pss_out = pc_out[1];
endmodule // ipc_cpu_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  ipc_pkg::ipc_sfr_s sfr = '0;
  logic irq = 1'b0;
  logic ext = 1'b0;
  logic [1:0] smode = 2'h0;
  logic ale, pss, cen, osc, pen, ram, bd, sleep_request_bit, pd;
  logic [7:0] rdata, pc;
  ipc_pkg::ipc_pins_s pins;
  int bad_count = 0;
  int num_checks = 0;
  int st = 0;
  int rst_left = 12;
  logic [7:0] m_reg = 8'h00;
  logic [7:0] m_rd = 8'h00;
  logic [7:0] m_pc = 8'h00;
  logic [3:0] e_pins;
  logic [31:0] seed = 32'h0000fc68;
  logic [31:0] r, q;

  // 20 mhz clock
  always #25 clk_in = ~clk_in;

  ipc_power_ctrl i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .sfr_in(sfr),
    .irq_enabled_in(irq), .ext_program_in(ext), .serial_mode_in(smode),
    .cpu_ale_in(ale), .cpu_prog_store_strobe_in(pss), .rdata_out(rdata),
    .osc_run_out(osc), .cpu_clk_en_out(cen), .periph_clk_en_out(pen),
    .ram_retain_out(ram), .baud_double_out(bd), .idle_out(sleep_request_bit),
    .power_down_out(pd), .pins_out(pins));
  ipc_cpu_model i_cpu (.clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(cen),
    .ale_out(ale), .pss_out(pss), .pc_out(pc));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // random cpu traffic, compared with the model every cycle
  initial
  begin
    repeat (3000)
    begin
      @(negedge clk_in);
      m_pc = !rstn_in ? 8'h00 : (st == 0 ? m_pc + 8'h01 : m_pc);
      seed = xs(seed);
      r = seed;
      seed = xs(seed);
      q = seed;
      if (rst_left == 0 && (st == 2 ? r[3:0] == 0 : r[11:4] == 0))
        rst_left = 24;
      rstn_in <= (rst_left == 0);
      if (rst_left > 0)
        rst_left--;
      sfr.wr <= r[12];
      sfr.rd <= !r[12] && r[13] && st == 0;
      sfr.bit_access <= r[12] && r[15:14] == 2'h0;
      sfr.addr <= r[17:16] == 2'h0 ? r[25:18] : ipc_pkg::PWR_CTRL_ADDR;
      sfr.wdata <= q[7:0];
      irq <= q[10:8] == 3'h0;
      ext <= q[11];
      smode <= q[13:12];
      #1;
      e_pins = st == 0 ? {ale, pss, 1'b0, ext} :
        st == 1 ? {{2{ipc_pkg::STROBE_IDLE}}, ext, ext} :
        {{2{ipc_pkg::STROBE_PDOWN}}, ext, 1'b0};
      chk("rdata", m_rd, rdata);
      chk("idle", st == 1, sleep_request_bit);
      chk("pdown", st == 2, pd);
      chk("cpu_clk", st == 0, cen);
      chk("osc", st != 2, osc);
      chk("periph", st != 2, pen);
      chk("ram", 8'h01, ram);
      chk("baud", m_reg[7] && smode != 2'h0, bd);
      chk("pins", e_pins, pins);
      chk("pc", m_pc, pc);
      m_rd = sfr.rd && sfr.addr == ipc_pkg::PWR_CTRL_ADDR ? m_reg : 8'h00;
      if (!rstn_in)
      begin
        m_reg = ipc_pkg::PWR_CTRL_RESET;
        st = 0;
        m_rd = 8'h00;
      end
      else if (st == 1 && irq)
      begin
        st = 0;
        m_reg[0] = 1'b0;
      end
      else if (st == 0 && sfr.wr && !sfr.bit_access &&
        sfr.addr == ipc_pkg::PWR_CTRL_ADDR)
      begin
        m_reg = sfr.wdata & ipc_pkg::PWR_CTRL_MASK;
        m_reg[0] = m_reg[0] && !m_reg[1];
        st = m_reg[1] ? 2 : (m_reg[0] ? 1 : 0);
      end
    end
    tally_and_finish;
  end

  // watchdog against a hang
  initial
  begin
    #(50 * 4000);
    bad_count++;
    tally_and_finish;
  end
endmodule // tb_top
